// [counter_array_module_regs.sv]
`timescale 1ns/100ps
module counter_array_module_regs #(
	parameter int NUM_MOD = 6
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire counter_array_pkg::sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata,
	input wire logic watchdog_en,
	input wire logic count_tick,
	input wire logic [NUM_MOD-1:0] capture_in,
	input wire logic [NUM_MOD-1:0] flag_clear,
	output logic [NUM_MOD-1:0] capcmp_flag,
	output logic [NUM_MOD-1:0] module_out_pin,
	output logic counter_array_irq,
	output logic watchdog_expire
);

	localparam int WDT = NUM_MOD - 1;

	// Address tables only cover six modules
	if (NUM_MOD < 1 || NUM_MOD > counter_array_pkg::MAX_MOD) begin : g_chk
		$error("NUM_MOD must be 1 to 6");
	end

	function automatic logic [NUM_MOD-1:0] hit(
		input logic [7:0] a,
		input logic [7:0] tbl [counter_array_pkg::MAX_MOD]
	);
		logic [NUM_MOD-1:0] r;
		r = '0;
		for (int k = 0; k < NUM_MOD; k++) begin
			r[k] = (a == tbl[k]);
		end
		return r;
	endfunction : hit

	function automatic counter_array_pkg::out_mode_t out_mode(
		input counter_array_pkg::mode_t m
	);
		if (m.toggle_en && m.pulse_width_en)
			return counter_array_pkg::OM_FREQ;
		if (m.pulse_width_en)
			return m.wide_pwm_sel ? counter_array_pkg::OM_PWM16 :
				counter_array_pkg::OM_PWM;
		if (m.toggle_en)
			return counter_array_pkg::OM_TOGGLE;
		return counter_array_pkg::OM_IDLE;
	endfunction : out_mode

	logic [15:0] cnt, next_cnt, cyc_mask;
	logic cyc_wrap, view_sel, cov_ie, cov_flag;
	logic [1:0] len_sel;
	logic wr_cnt_low, wr_cnt_high, wr_pcfg;
	logic [NUM_MOD-1:0] wr_mode, wr_low, wr_high;
	logic [NUM_MOD-1:0] cap_s1, cap_s2, cap_s3, rise, fall;
	logic [NUM_MOD-1:0] match, capt, irq_en;
	counter_array_pkg::mode_t mode [NUM_MOD];
	counter_array_pkg::out_mode_t om [NUM_MOD];
	logic [15:0] val [NUM_MOD];
	logic [15:0] reload [NUM_MOD];
	logic [7:0] rd_value;

	assign next_cnt = cnt + 16'h0001;
	assign wr_cnt_low = sfr_req.wr &&
		sfr_req.addr == counter_array_pkg::ADDR_CNT_LOW;
	assign wr_cnt_high = sfr_req.wr &&
		sfr_req.addr == counter_array_pkg::ADDR_CNT_HIGH;
	assign wr_pcfg = sfr_req.wr &&
		sfr_req.addr == counter_array_pkg::ADDR_PULSE_CFG;
	assign wr_mode = {NUM_MOD{sfr_req.wr}} &
		hit(sfr_req.addr, counter_array_pkg::ADDR_MODE);
	assign wr_low = {NUM_MOD{sfr_req.wr}} &
		hit(sfr_req.addr, counter_array_pkg::ADDR_VAL_LOW);
	assign wr_high = {NUM_MOD{sfr_req.wr}} &
		hit(sfr_req.addr, counter_array_pkg::ADDR_VAL_HIGH);

	// Software writes win over a tick in the same cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt <= counter_array_pkg::VAL_RESET;
		end else if (wr_cnt_low && !watchdog_en) begin
			cnt[7:0] <= sfr_req.wdata;
		end else if (wr_cnt_high && !watchdog_en) begin
			cnt[15:8] <= sfr_req.wdata;
		end else if (count_tick) begin
			cnt <= next_cnt;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			view_sel <= 1'b0;
			cov_ie <= 1'b0;
			len_sel <= 2'b00;
		end else if (wr_pcfg) begin
			view_sel <= sfr_req.wdata[counter_array_pkg::PCFG_VIEW_BIT];
			cov_ie <= sfr_req.wdata[counter_array_pkg::PCFG_COV_IE_BIT];
			len_sel <= sfr_req.wdata[counter_array_pkg::PCFG_LEN_LSB +:
				counter_array_pkg::PCFG_LEN_W];
		end
	end

	// A wrap in the cycle of a clearing write still leaves the flag set
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cov_flag <= 1'b0;
		end else if (cyc_wrap) begin
			cov_flag <= 1'b1;
		end else if (wr_pcfg) begin
			cov_flag <= sfr_req.wdata[counter_array_pkg::PCFG_COV_BIT];
		end
	end

	assign cyc_mask = (counter_array_pkg::BASE_CYCLE << len_sel) -
		16'h0001;
	assign cyc_wrap = count_tick && ((next_cnt & cyc_mask) == 16'h0000);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cap_s1 <= '0;
			cap_s2 <= '0;
			cap_s3 <= '0;
		end else begin
			cap_s1 <= capture_in;
			cap_s2 <= cap_s1;
			cap_s3 <= cap_s2;
		end
	end

	assign rise = cap_s2 & ~cap_s3;
	assign fall = ~cap_s2 & cap_s3;

	for (genvar i = 0; i < NUM_MOD; i++) begin : g_mod
		logic lock;
		logic hit_cmp;

		// Module 5 serves the watchdog while it is enabled
		assign lock = (i == WDT) && (NUM_MOD == 6) && watchdog_en;
		assign om[i] = out_mode(mode[i]);
		assign irq_en[i] = mode[i].flag_irq_en;

		always_comb begin
			unique case (om[i])
				counter_array_pkg::OM_FREQ:
					hit_cmp = cnt[7:0] == val[i][7:0];
				counter_array_pkg::OM_PWM:
					hit_cmp = (cnt & cyc_mask) == (val[i] & cyc_mask);
				default:
					hit_cmp = cnt == val[i];
			endcase
		end

		// Match is taken on the counter value present at the tick
		assign match[i] = count_tick && !lock &&
			mode[i].compare_enable && hit_cmp;
		assign capt[i] = !lock &&
			((rise[i] && mode[i].rise_capture_en) ||
			(fall[i] && mode[i].fall_capture_en));

		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				mode[i] <= counter_array_pkg::MODE_RESET;
			end else if (lock) begin
				mode[i] <= mode[i];
			end else if (wr_mode[i]) begin
				mode[i] <= sfr_req.wdata;
			end else if (wr_low[i]) begin
				mode[i].compare_enable <= 1'b0;
			end else if (wr_high[i]) begin
				mode[i].compare_enable <= 1'b1;
			end
		end

		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				reload[i] <= counter_array_pkg::VAL_RESET;
			end else if (wr_low[i] && view_sel) begin
				reload[i][7:0] <= sfr_req.wdata;
			end else if (wr_high[i] && view_sel) begin
				reload[i][15:8] <= sfr_req.wdata;
			end
		end

		// In shared-cycle PWM the duty value is refreshed at the wrap, so
		// software can change it without a glitch mid-cycle
		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				val[i] <= counter_array_pkg::VAL_RESET;
			end else if (wr_low[i] && !view_sel) begin
				val[i][7:0] <= sfr_req.wdata;
			end else if (wr_high[i] && !view_sel) begin
				val[i][15:8] <= sfr_req.wdata;
			end else if (capt[i]) begin
				val[i] <= cnt;
			end else if (om[i] == counter_array_pkg::OM_FREQ && match[i]) begin
				val[i][7:0] <= val[i][7:0] + val[i][15:8];
			end else if (om[i] == counter_array_pkg::OM_PWM && cyc_wrap) begin
				if (len_sel == 2'b00)
					val[i][7:0] <= val[i][15:8];
				else
					val[i] <= reload[i];
			end
		end

		// Flag set by an event wins over a clear in the same cycle
		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				capcmp_flag[i] <= 1'b0;
			end else if (capt[i] || (match[i] && mode[i].match_flag_en)) begin
				capcmp_flag[i] <= 1'b1;
			end else if (flag_clear[i]) begin
				capcmp_flag[i] <= 1'b0;
			end
		end

		// Match beats wrap so a duty value equal to cyc_mask keeps the pin low
		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				module_out_pin[i] <= 1'b0;
			end else if (!lock) begin
				unique case (om[i])
					counter_array_pkg::OM_TOGGLE,
					counter_array_pkg::OM_FREQ: begin
						if (match[i])
							module_out_pin[i] <= ~module_out_pin[i];
					end
					counter_array_pkg::OM_PWM: begin
						if (match[i])
							module_out_pin[i] <= 1'b0;
						else if (cyc_wrap)
							module_out_pin[i] <= 1'b1;
					end
					counter_array_pkg::OM_PWM16: begin
						if (match[i])
							module_out_pin[i] <= 1'b0;
						else if (count_tick && next_cnt == 16'h0000)
							module_out_pin[i] <= 1'b1;
					end
					counter_array_pkg::OM_IDLE: begin
						module_out_pin[i] <= module_out_pin[i];
					end
				endcase
			end
		end
	end

	assign counter_array_irq = (|(capcmp_flag & irq_en)) ||
		(cov_flag && cov_ie);

	// Watchdog fires when the counter high byte meets module 5's high byte
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			watchdog_expire <= 1'b0;
		end else begin
			watchdog_expire <= g_mod[WDT].lock && count_tick &&
				cnt[15:8] == val[WDT][15:8];
		end
	end

	always_comb begin
		rd_value = counter_array_pkg::UNMAPPED_READ;
		if (sfr_req.addr == counter_array_pkg::ADDR_CNT_LOW)
			rd_value = cnt[7:0];
		if (sfr_req.addr == counter_array_pkg::ADDR_CNT_HIGH)
			rd_value = cnt[15:8];
		if (sfr_req.addr == counter_array_pkg::ADDR_PULSE_CFG)
			rd_value = {view_sel, cov_ie, cov_flag, 3'b000, len_sel};
		for (int k = 0; k < NUM_MOD; k++) begin
			if (sfr_req.addr == counter_array_pkg::ADDR_MODE[k])
				rd_value = mode[k];
			if (sfr_req.addr == counter_array_pkg::ADDR_VAL_LOW[k])
				rd_value = view_sel ? reload[k][7:0] : val[k][7:0];
			if (sfr_req.addr == counter_array_pkg::ADDR_VAL_HIGH[k])
				rd_value = view_sel ? reload[k][15:8] : val[k][15:8];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_req.rd) begin
			sfr_rdata <= rd_value;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	property p_low_clears_ce;
		wr_low[0] |=> !mode[0].compare_enable;
	endproperty
	a_low_clears_ce: assert property (p_low_clears_ce)
		else $error("low byte write left compare enabled");

	property p_high_sets_ce;
		wr_high[0] |=> mode[0].compare_enable;
	endproperty
	a_high_sets_ce: assert property (p_high_sets_ce)
		else $error("high byte write did not enable compare");

	property p_wdt_mode_lock;
		watchdog_en && wr_mode[WDT] && NUM_MOD == 6 |=> $stable(mode[WDT]);
	endproperty
	a_wdt_mode_lock: assert property (p_wdt_mode_lock)
		else $error("locked module mode changed");

	property p_cnt_low_lock;
		watchdog_en && wr_cnt_low && !count_tick |=>
			cnt[7:0] == $past(cnt[7:0]);
	endproperty
	a_cnt_low_lock: assert property (p_cnt_low_lock)
		else $error("counter low byte written under watchdog");

	property p_cnt_high_lock;
		watchdog_en && wr_cnt_high && !count_tick |=>
			cnt[15:8] == $past(cnt[15:8]);
	endproperty
	a_cnt_high_lock: assert property (p_cnt_high_lock)
		else $error("counter high byte written under watchdog");

	property p_cnt_write;
		wr_cnt_low && !watchdog_en |=> cnt[7:0] == $past(sfr_req.wdata);
	endproperty
	a_cnt_write: assert property (p_cnt_write)
		else $error("counter low byte write lost");

	property p_rise_capture;
		mode[0].rise_capture_en && rise[0] && !wr_low[0] && !wr_high[0]
			|=> val[0] == $past(cnt);
	endproperty
	a_rise_capture: assert property (p_rise_capture)
		else $error("rising edge did not capture counter");

	property p_fall_capture;
		mode[0].fall_capture_en && fall[0] && !wr_low[0] && !wr_high[0]
			|=> val[0] == $past(cnt) && capcmp_flag[0];
	endproperty
	a_fall_capture: assert property (p_fall_capture)
		else $error("falling edge did not capture counter");

	property p_match_flag;
		match[0] && mode[0].match_flag_en |=> capcmp_flag[0];
	endproperty
	a_match_flag: assert property (p_match_flag)
		else $error("match did not set flag");

	property p_toggle;
		match[0] && om[0] == counter_array_pkg::OM_TOGGLE |=>
			module_out_pin[0] != $past(module_out_pin[0]);
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("match did not toggle pin");

	property p_irq;
		capcmp_flag[0] && mode[0].flag_irq_en |-> counter_array_irq;
	endproperty
	a_irq: assert property (p_irq)
		else $error("enabled flag gave no interrupt");

	property p_reload_view;
		wr_low[0] && view_sel && !capt[0] && !count_tick |=>
			reload[0][7:0] == $past(sfr_req.wdata) &&
			val[0] == $past(val[0]);
	endproperty
	a_reload_view: assert property (p_reload_view)
		else $error("reload view write went astray");

	c_capture: cover property (rise[0] && mode[0].rise_capture_en);
	c_freq: cover property (match[0] && om[0] == counter_array_pkg::OM_FREQ);
	c_pwm_wrap: cover property (cyc_wrap && om[0] == counter_array_pkg::OM_PWM);
	c_watchdog: cover property (watchdog_expire);

endmodule : counter_array_module_regs

// [counter_array_module_regs_tb_top.sv]
`timescale 1ns/100ps
module counter_array_module_regs_tb_top;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	counter_array_pkg::sfr_req_t sfr_req;
	logic [7:0] sfr_rdata;
	logic watchdog_en = 1'b0;
	logic count_tick = 1'b0;
	logic [5:0] capture_in = 6'h00;
	logic [5:0] flag_clear = 6'h00;
	logic [5:0] capcmp_flag;
	logic [5:0] module_out_pin;
	logic counter_array_irq;
	logic watchdog_expire;
	int fails = 0;
	int comparisons = 0;

	always #2 core_clk = ~core_clk;

	sfr_core_model core (
		.core_clk(core_clk),
		.sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata)
	);

	counter_array_module_regs #(.NUM_MOD(6)) DUT (
		.core_clk(core_clk),
		.rst(rst),
		.sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata),
		.watchdog_en(watchdog_en),
		.count_tick(count_tick),
		.capture_in(capture_in),
		.flag_clear(flag_clear),
		.capcmp_flag(capcmp_flag),
		.module_out_pin(module_out_pin),
		.counter_array_irq(counter_array_irq),
		.watchdog_expire(watchdog_expire)
	);

	task automatic summarize();
		if (fails == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize

	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
		end
	endtask : check_byte

	task automatic check_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
		end
	endtask : check_bit

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		core.rd(a, d);
		check_byte(d, exp);
	endtask : rd_chk

	// Ticks are spaced by an idle cycle so each one is a separate pulse
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge core_clk);
			count_tick <= 1'b1;
			@(posedge core_clk);
			count_tick <= 1'b0;
		end
		#1;
	endtask : tick

	task automatic reset_values();
		for (int i = 0; i < 6; i++) begin
			rd_chk(counter_array_pkg::ADDR_MODE[i], 8'h00);
			rd_chk(counter_array_pkg::ADDR_VAL_LOW[i], 8'h00);
		end
		rd_chk(8'hf9, 8'h00);
		rd_chk(8'hfa, 8'h00);
		rd_chk(8'h00, 8'h00);
		check_byte({capcmp_flag, 2'b00}, 8'h00);
		check_byte({module_out_pin, 2'b00}, 8'h00);
	endtask : reset_values

	task automatic watchdog_lock();
		@(posedge core_clk);
		watchdog_en <= 1'b1;
		core.wr(8'hf9, 8'h11);
		core.wr(8'hfa, 8'h22);
		core.wr(8'hce, 8'h55);
		rd_chk(8'hf9, 8'h00);
		rd_chk(8'hfa, 8'h00);
		rd_chk(8'hce, 8'h00);
		@(posedge core_clk);
		watchdog_en <= 1'b0;
		core.wr(8'hce, 8'h55);
		core.wr(8'hf9, 8'h11);
		core.wr(8'hfa, 8'h22);
		rd_chk(8'hce, 8'h55);
		rd_chk(8'hf9, 8'h11);
		rd_chk(8'hfa, 8'h22);
		core.wr(8'hce, 8'h00);
	endtask : watchdog_lock

	task automatic compare_enable_side_effects();
		core.wr(8'hdb, 8'h40);
		core.wr(8'he9, 8'h12);
		rd_chk(8'hdb, 8'h00);
		core.wr(8'hea, 8'h34);
		rd_chk(8'hdb, 8'h40);
		rd_chk(8'he9, 8'h12);
		core.wr(8'hdb, 8'h00);
	endtask : compare_enable_side_effects

	task automatic match_toggle_irq();
		core.wr(8'hf9, 8'h00);
		core.wr(8'hfa, 8'h00);
		core.wr(8'hda, 8'h0d);
		core.wr(8'hfb, 8'h03);
		core.wr(8'hfc, 8'h00);
		tick(3);
		check_bit(capcmp_flag[0], 1'b0);
		tick(1);
		check_bit(capcmp_flag[0], 1'b1);
		check_bit(module_out_pin[0], 1'b1);
		check_bit(counter_array_irq, 1'b1);
		@(posedge core_clk);
		flag_clear <= 6'h01;
		@(posedge core_clk);
		flag_clear <= 6'h00;
		#1;
		check_bit(counter_array_irq, 1'b0);
		core.wr(8'hda, 8'h4c);
		core.wr(8'hfb, 8'h05);
		core.wr(8'hfc, 8'h00);
		tick(2);
		check_bit(capcmp_flag[0], 1'b1);
		check_bit(module_out_pin[0], 1'b0);
		check_bit(counter_array_irq, 1'b0);
	endtask : match_toggle_irq

	task automatic edge_capture();
		@(posedge core_clk);
		flag_clear <= 6'h01;
		@(posedge core_clk);
		flag_clear <= 6'h00;
		#1;
		check_bit(capcmp_flag[0], 1'b0);
		core.wr(8'hda, 8'h30);
		core.wr(8'hf9, 8'h34);
		core.wr(8'hfa, 8'h12);
		@(posedge core_clk);
		capture_in <= 6'h01;
		repeat (4) @(posedge core_clk);
		#1;
		check_bit(capcmp_flag[0], 1'b1);
		rd_chk(8'hfb, 8'h34);
		rd_chk(8'hfc, 8'h12);
		core.wr(8'hf9, 8'h56);
		@(posedge core_clk);
		capture_in <= 6'h00;
		repeat (4) @(posedge core_clk);
		rd_chk(8'hfb, 8'h56);
	endtask : edge_capture

	task automatic reload_view();
		core.wr(8'hdf, 8'hff);
		rd_chk(8'hdf, 8'he3);
		core.wr(8'hdf, 8'h80);
		core.wr(8'hfb, 8'haa);
		rd_chk(8'hfb, 8'haa);
		core.wr(8'hdf, 8'h00);
		rd_chk(8'hfb, 8'h56);
	endtask : reload_view

	// Over two full 8-bit cycles, half duty gives about 256 high cycles
	task automatic pwm_duty();
		int high;
		high = 0;
		core.wr(8'hdd, 8'h42);
		core.wr(8'hed, 8'h80);
		core.wr(8'hee, 8'h80);
		@(posedge core_clk);
		count_tick <= 1'b1;
		repeat (64) @(posedge core_clk);
		repeat (512) begin
			@(posedge core_clk);
			#1;
			if (module_out_pin[3] === 1'b1) begin
				high++;
			end
		end
		@(posedge core_clk);
		count_tick <= 1'b0;
		check_bit(high >= 252 && high <= 260, 1'b1);
	endtask : pwm_duty

	// Plain toggle would need the full 16-bit value and never fire here
	task automatic freq_output();
		core.wr(8'hf9, 8'h00);
		core.wr(8'hfa, 8'h00);
		core.wr(8'hde, 8'h46);
		core.wr(8'hfd, 8'h02);
		core.wr(8'hfe, 8'h03);
		tick(3);
		check_bit(module_out_pin[4], 1'b1);
		tick(3);
		check_bit(module_out_pin[4], 1'b0);
		rd_chk(8'hfd, 8'h08);
	endtask : freq_output

	// An 8-bit cycle would already have matched on the low byte
	task automatic wide_pwm();
		core.wr(8'hdc, 8'hc2);
		core.wr(8'heb, 8'h01);
		core.wr(8'hec, 8'h01);
		core.wr(8'hf9, 8'hfe);
		core.wr(8'hfa, 8'hff);
		tick(4);
		check_bit(module_out_pin[2], 1'b1);
		core.wr(8'hf9, 8'h01);
		core.wr(8'hfa, 8'h01);
		tick(1);
		check_bit(module_out_pin[2], 1'b0);
	endtask : wide_pwm

	task automatic cycle_overflow();
		core.wr(8'hdf, 8'h41);
		core.wr(8'hf9, 8'hff);
		core.wr(8'hfa, 8'h00);
		tick(1);
		rd_chk(8'hdf, 8'h41);
		check_bit(counter_array_irq, 1'b0);
		core.wr(8'hfa, 8'h01);
		core.wr(8'hf9, 8'hff);
		tick(1);
		rd_chk(8'hdf, 8'h61);
		check_bit(counter_array_irq, 1'b1);
		core.wr(8'hdf, 8'h00);
	endtask : cycle_overflow

	task automatic watchdog_timeout();
		core.wr(8'hf9, 8'h00);
		core.wr(8'hfa, 8'h00);
		@(posedge core_clk);
		watchdog_en <= 1'b1;
		tick(1);
		check_bit(watchdog_expire, 1'b1);
		@(posedge core_clk);
		#1;
		check_bit(watchdog_expire, 1'b0);
		@(posedge core_clk);
		watchdog_en <= 1'b0;
		tick(1);
		check_bit(watchdog_expire, 1'b0);
	endtask : watchdog_timeout

	initial begin
		#200000;
		fails++;
		summarize();
	end

	initial begin
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		reset_values();
		watchdog_lock();
		compare_enable_side_effects();
		match_toggle_irq();
		edge_capture();
		reload_view();
		pwm_duty();
		freq_output();
		wide_pwm();
		cycle_overflow();
		watchdog_timeout();
		summarize();
	end
endmodule : counter_array_module_regs_tb_top

// [counter_array_pkg.sv]
package counter_array_pkg;

	localparam int MAX_MOD = 6;
	localparam int CNT_W = 16;
	localparam int BYTE_W = 8;
	localparam int SYNC_STAGES = 2;

	localparam logic [7:0] ADDR_CNT_LOW = 8'hf9;
	localparam logic [7:0] ADDR_CNT_HIGH = 8'hfa;
	localparam logic [7:0] ADDR_PULSE_CFG = 8'hdf;
	localparam logic [7:0] ADDR_MODE [MAX_MOD] =
		'{8'hda, 8'hdb, 8'hdc, 8'hdd, 8'hde, 8'hce};
	localparam logic [7:0] ADDR_VAL_LOW [MAX_MOD] =
		'{8'hfb, 8'he9, 8'heb, 8'hed, 8'hfd, 8'hd2};
	localparam logic [7:0] ADDR_VAL_HIGH [MAX_MOD] =
		'{8'hfc, 8'hea, 8'hec, 8'hee, 8'hfe, 8'hd3};

	// Field positions of the pulse configuration register
	localparam int PCFG_VIEW_BIT = 7;
	localparam int PCFG_COV_IE_BIT = 6;
	localparam int PCFG_COV_BIT = 5;
	localparam int PCFG_LEN_LSB = 0;
	localparam int PCFG_LEN_W = 2;
	localparam logic [7:0] PCFG_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [15:0] VAL_RESET = 16'h0000;
	localparam logic [15:0] BASE_CYCLE = 16'h0100;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// Bit 7 down to bit 0 of a module's mode register
	typedef struct packed {
		logic wide_pwm_sel;
		logic compare_enable;
		logic rise_capture_en;
		logic fall_capture_en;
		logic match_flag_en;
		logic toggle_en;
		logic pulse_width_en;
		logic flag_irq_en;
	} mode_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

	typedef enum logic [2:0] {
		OM_IDLE = 3'b000,
		OM_TOGGLE = 3'b001,
		OM_PWM = 3'b010,
		OM_PWM16 = 3'b011,
		OM_FREQ = 3'b100
	} out_mode_t;

endpackage : counter_array_pkg

// [sfr_core_model.sv]
`timescale 1ns/100ps
module sfr_core_model (
	input wire logic core_clk,
	output counter_array_pkg::sfr_req_t sfr_req,
	input wire logic [7:0] sfr_rdata
);
	initial begin
		sfr_req = '0;
	end

	// Released address and data lines show the inverse of the last value,
	// so that the block never sees a stale request that still looks valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		sfr_req <= '{1'b1, 1'b0, a, d};
		@(posedge core_clk);
		sfr_req <= '{1'b0, 1'b0, ~a, ~d};
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		sfr_req <= '{1'b0, 1'b1, a, ~sfr_req.wdata};
		@(posedge core_clk);
		sfr_req <= '{1'b0, 1'b0, ~a, ~sfr_req.wdata};
		#1;
		d = sfr_rdata;
	endtask : rd
endmodule : sfr_core_model
